// [src/rfsbp_top.sv]
// Receive status bus packer: places lane data and status on a 32-bit word.
// Assumes lane records and mode are synchronous to sys_clk.
//
// Function
// - 8-bit 8B/10B: decoded byte on bits 7:0.
// - 8-bit 8B/10B: control-character flag on bit 8.
// - 8-bit 8B/10B: code-group violation on bit 9.
// - 8-bit widths: disparity error on bit 11.
// - 8-bit widths: alignment pattern detected on bit 12.
// - Non-PIPE modes: rate-match deletion flag on bit 13.
// - Non-PIPE modes: rate-match insertion flag on bit 14.
// - PIPE mode: bits 14:13 carry the two-bit protocol receive status.
// - 8-bit and 10-bit widths: running disparity on bit 15.
// - 10-bit width: undecoded ten-bit code group on bits 9:0.
// - 10-bit width: sync status on bit 10, disparity error bit 11.
// - 16-bit width: lower byte on 7:0, upper byte on 23:16.
// - 16-bit 8B/10B: control flags on bits 8 and 24.
// - 16-bit 8B/10B: code-violation flags on bits 9 and 25.
// - 16-bit width: sync-status flags on bits 10 and 26.
// - 16-bit width: disparity-error flags on bits 11 and 27.
`timescale 1ns/100ps
`include "rfsbp_cfg.svh"
module rfsbp_top
   import rfsbp_pkg::*;
#(
   parameter int FIFO_DEPTH = `RFSBP_FIFO_DEPTH
) (
   input  wire logic                    sys_clk,
   input  wire logic                    sys_rst,
   input  rfsbp_mode_type               mode,
   input  rfsbp_lane_type               lane_lo,
   input  rfsbp_lane_type               lane_hi,
   input  wire logic                    in_valid,
   output logic                         in_ready,
   output logic [`RFSBP_BUS_W-1:0]      rx_word,
   output logic                         rx_valid,
   input  wire logic                    rx_ready
);

   ////////////////////////////////////////////////////////////////////////////
   // Packing of one 16-bit half.

   // Control and violation flags only exist after the decoder, so raw
   // 10-bit symbols put symbol bits 9:8 in those positions and non-8B/10B byte modes hold them at zero.
   function automatic logic [`RFSBP_HALF_W-1:0] pack_half(
      input rfsbp_lane_type l,
      input logic           raw10,
      input logic           enc,
      input logic           pipe
   );
      logic [`RFSBP_HALF_W-1:0] h;
      h = '0;
      if (raw10) begin
         h[`RFSBP_SYM_MSB:0] = l.sym;
      end else begin
         h[`RFSBP_BYTE_MSB:0]   = l.sym[`RFSBP_BYTE_MSB:0];
         h[`RFSBP_CTRL_BIT]     = enc & l.ctrl;
         h[`RFSBP_CVIOL_BIT]    = enc & l.cviol;
      end
      h[`RFSBP_SYNC_BIT] = l.sync;
      h[`RFSBP_DERR_BIT] = l.derr;
      h[`RFSBP_PDET_BIT] = l.pdet;
      if (pipe) begin
         h[`RFSBP_PSTAT_MSB:`RFSBP_PSTAT_LSB] = l.pstat;
      end else begin
         h[`RFSBP_RMDEL_BIT] = l.rmdel;
         h[`RFSBP_RMINS_BIT] = l.rmins;
      end
      h[`RFSBP_RDISP_BIT] = l.rdisp;
      return h;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode and word assembly.

   // A width code that is not one of the three one-hot values falls back
   // to the 8-bit layout, so the upper half stays quiet.
   wire                       is_w10 = (mode.width == RFSBP_W10);
   wire                       is_w16 = (mode.width == RFSBP_W16);
   wire                       is_w8  = !is_w10 && !is_w16;
   wire [`RFSBP_HALF_W-1:0]   half_lo;
   wire [`RFSBP_HALF_W-1:0]   half_hi;
   wire [`RFSBP_BUS_W-1:0]    packed_word;
   wire [$clog2(FIFO_DEPTH):0] fifo_level;

   assign half_lo     = pack_half(lane_lo, is_w10, mode.enc_8b10b, mode.pipe);
   assign half_hi     = is_w16 ? pack_half(lane_hi, 1'b0, mode.enc_8b10b, mode.pipe)
                               : '0;
   assign packed_word = {half_hi, half_lo};

   ////////////////////////////////////////////////////////////////////////////
   // Buffer toward the core; a stalled consumer back-pressures in_ready.

   rfsbp_fifo #(.W(`RFSBP_BUS_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .in_valid  (in_valid),
      .in_ready  (in_ready),
      .in_data   (packed_word),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .out_data  (rx_word),
      .level     (fifo_level)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the packed word at the moment it enters the buffer.

   wire take = in_valid && in_ready;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_take_enc8;
      take && is_w8 && mode.enc_8b10b;
   endsequence

   sequence s_take_w16_enc;
      take && is_w16 && mode.enc_8b10b;
   endsequence

   sequence s_take_idle;
      take && (fifo_level == '0) && !rx_valid && rx_ready;
   endsequence

   a_byte_low: assert property (s_take_enc8 |-> packed_word[7:0] == lane_lo.sym[7:0])
      else $error("Lower byte not placed on bits 7:0.");
   a_ctrl_flag: assert property (s_take_enc8 |-> packed_word[8] == lane_lo.ctrl)
      else $error("Control flag not on bit 8.");
   a_code_viol: assert property (s_take_enc8 |-> packed_word[9] == lane_lo.cviol)
      else $error("Code violation not on bit 9.");
   a_disp_err8: assert property (take && is_w8 |-> packed_word[11] == lane_lo.derr)
      else $error("Disparity error not on bit 11.");
   a_pattern_det: assert property (take && is_w8 |-> packed_word[12] == lane_lo.pdet)
      else $error("Pattern detect not on bit 12.");
   a_rm_delete: assert property (take && !mode.pipe |-> packed_word[13] == lane_lo.rmdel)
      else $error("Rate-match deletion not on bit 13.");
   a_rm_insert: assert property (take && !mode.pipe |-> packed_word[14] == lane_lo.rmins)
      else $error("Rate-match insertion not on bit 14.");
   a_pipe_status: assert property (take && mode.pipe |-> packed_word[14:13] == lane_lo.pstat)
      else $error("Protocol status not on bits 14:13.");
   a_run_disp: assert property (take && !is_w16 |-> packed_word[15] == lane_lo.rdisp)
      else $error("Running disparity not on bit 15.");
   a_raw_symbol: assert property (take && is_w10 |-> packed_word[9:0] == lane_lo.sym)
      else $error("Ten-bit symbol not on bits 9:0.");
   a_sync_w10: assert property (take && is_w10 |->
         packed_word[11:10] == {lane_lo.derr, lane_lo.sync})
      else $error("Sync or disparity error misplaced in 10-bit width.");
   a_two_bytes: assert property (take && is_w16 |->
         {packed_word[23:16], packed_word[7:0]} ==
         {lane_hi.sym[7:0], lane_lo.sym[7:0]})
      else $error("Bytes misplaced in 16-bit width.");
   a_ctrl_pair: assert property (s_take_w16_enc |->
         {packed_word[24], packed_word[8]} == {lane_hi.ctrl, lane_lo.ctrl})
      else $error("Control flags misplaced in 16-bit width.");
   a_viol_pair: assert property (s_take_w16_enc |->
         {packed_word[25], packed_word[9]} == {lane_hi.cviol, lane_lo.cviol})
      else $error("Violation flags misplaced in 16-bit width.");
   a_sync_pair: assert property (take && is_w16 |->
         {packed_word[26], packed_word[10]} == {lane_hi.sync, lane_lo.sync})
      else $error("Sync flags misplaced in 16-bit width.");
   a_derr_pair: assert property (take && is_w16 |->
         {packed_word[27], packed_word[11]} == {lane_hi.derr, lane_lo.derr})
      else $error("Disparity error flags misplaced in 16-bit width.");
   a_upper_zero: assert property (take && !is_w16 |-> packed_word[31:16] == '0)
      else $error("Upper half not zero in 8-bit or 10-bit width.");
   // The word is written at the take edge and read at the next, so it shows after two.
   a_idle_delivery: assert property (s_take_idle ##0 !is_w16 |->
         ##2 (rx_valid && rx_word == $past(packed_word, 2) && rx_word[31:16] == '0))
      else $error("Word through an idle buffer did not arrive two edges after its take.");

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the buffer handshake and on the upper-half layout choices.

   sequence s_stalled;
      rx_valid && !rx_ready;
   endsequence

   a_word_hold: assert property (s_stalled |=> rx_valid && $stable(rx_word))
      else $error("Delivered word changed while the consumer stalled.");
   a_full_refuse: assert property (fifo_level == FIFO_DEPTH |-> !in_ready)
      else $error("Buffer accepted a word while full.");
   a_free_accept: assert property (fifo_level < FIFO_DEPTH |-> in_ready)
      else $error("Buffer refused a word while it had room.");
   a_head_refill: assert property (fifo_level != '0 && !rx_valid |=> rx_valid)
      else $error("Stored word was not moved to the output register.");
   a_flags_plain: assert property (take && !mode.enc_8b10b && !is_w10 |->
         {packed_word[25:24], packed_word[9:8]} == 4'h0)
      else $error("Control or violation flags set outside 8B/10B modes.");
   a_hi_status: assert property (take && is_w16 |->
         packed_word[31:28] == {lane_hi.rdisp,
            (mode.pipe ? lane_hi.pstat : {lane_hi.rmins, lane_hi.rmdel}), lane_hi.pdet})
      else $error("Upper status bits misplaced in 16-bit width.");

endmodule

// [src/rfsbp_cfg.svh]
// Bit positions and sizes of the packed receive status bus.
// Assumes a 32-bit bus made of two 16-bit halves with one layout each.
`ifndef RFSBP_CFG_SVH
`define RFSBP_CFG_SVH

`define RFSBP_BUS_W      32
`define RFSBP_HALF_W     16
`define RFSBP_UPPER_LSB  16
`define RFSBP_SYM_W      10
`define RFSBP_BYTE_MSB   7
`define RFSBP_SYM_MSB    9
`define RFSBP_CTRL_BIT   8
`define RFSBP_CVIOL_BIT  9
`define RFSBP_SYNC_BIT   10
`define RFSBP_DERR_BIT   11
`define RFSBP_PDET_BIT   12
`define RFSBP_RMDEL_BIT  13
`define RFSBP_RMINS_BIT  14
`define RFSBP_PSTAT_LSB  13
`define RFSBP_PSTAT_MSB  14
`define RFSBP_RDISP_BIT  15
`define RFSBP_FIFO_DEPTH 8

`endif

// [src/rfsbp_pkg.sv]
// Types shared by the receive status bus packer.
// Assumes the decoder side hands over one lane record per received character.
package rfsbp_pkg;

   typedef enum logic [2:0] {
      RFSBP_W8  = 3'h1,
      RFSBP_W10 = 3'h2,
      RFSBP_W16 = 3'h4
   } rfsbp_width_type;

   typedef struct packed {
      logic [9:0] sym;
      logic       ctrl;
      logic       cviol;
      logic       sync;
      logic       derr;
      logic       pdet;
      logic       rmdel;
      logic       rmins;
      logic [1:0] pstat;
      logic       rdisp;
   } rfsbp_lane_type;

   typedef struct packed {
      rfsbp_width_type width;
      logic            enc_8b10b;
      logic            pipe;
   } rfsbp_mode_type;

endpackage

// [src/rfsbp_mem.sv]
// Small dual-port word store with a registered read port.
// Assumes the caller never reads an address in the cycle it writes it.
`timescale 1ns/100ps
module rfsbp_mem #(
   parameter int W     = 32,
   parameter int DEPTH = 8,
   parameter int AW    = 3
) (
   input  wire logic          sys_clk,
   input  wire logic          sys_rst,
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [W-1:0]  wr_data,
   input  wire logic          rd_en,
   input  wire logic [AW-1:0] rd_addr,
   output logic      [W-1:0]  rd_data_q
);

   logic [W-1:0] store [DEPTH];

   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         store[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_data_q <= '0;
      end else if (rd_en) begin
         rd_data_q <= store[rd_addr];
      end
   end

endmodule

// [src/rfsbp_fifo.sv]
// Word FIFO with valid and ready on both sides and a registered head.
// Assumes DEPTH is a power of two so the pointers wrap on their own.
`timescale 1ns/100ps
module rfsbp_fifo #(
   parameter int W     = 32,
   parameter int DEPTH = 8
) (
   input  wire logic                       sys_clk,
   input  wire logic                       sys_rst,
   input  wire logic                       in_valid,
   output logic                            in_ready,
   input  wire logic [W-1:0]               in_data,
   output logic                            out_valid,
   input  wire logic                       out_ready,
   output logic      [W-1:0]               out_data,
   output logic      [$clog2(DEPTH):0]     level
);

   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;

   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic          head_q;
   logic          head_d;
   wire           push = in_valid && in_ready;
   // The head register is refilled whenever a word is stored and the head is empty or being taken.
   wire           pop  = (cnt_q != '0) && (!head_q || out_ready);

   assign in_ready  = (cnt_q != CW'(DEPTH));
   assign out_valid = head_q;
   assign level     = cnt_q;
   assign cnt_d     = cnt_q + CW'(push) - CW'(pop);
   assign head_d    = pop ? 1'b1 : (out_ready ? 1'b0 : head_q);

   rfsbp_mem #(.W(W), .DEPTH(DEPTH), .AW(AW)) u_mem (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .wr_en     (push),
      .wr_addr   (wr_ptr_q),
      .wr_data   (in_data),
      .rd_en     (pop),
      .rd_addr   (rd_ptr_q),
      .rd_data_q (out_data)
   );

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q    <= '0;
         head_q   <= 1'b0;
      end else begin
         wr_ptr_q <= wr_ptr_q + AW'(push);
         rd_ptr_q <= rd_ptr_q + AW'(pop);
         cnt_q    <= cnt_d;
         head_q   <= head_d;
      end
   end

endmodule

// [tb/rfsbp_sink.sv]
// Behavioural consumer of the packed receive bus; it logs every word it takes.
// Assumes rx_word and rx_valid come from flip-flops clocked by sys_clk.
`timescale 1ns/100ps
module rfsbp_sink (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic [31:0] rx_word,
   input  wire logic        rx_valid,
   input  wire logic        stall,
   input  wire logic        slow,
   output logic             rx_ready
);
   logic [31:0] got[$];
   logic        phase;

   initial begin
      rx_ready = 1'b0;
      phase = 1'b0;
   end

   // Ready moves on the falling edge so the design samples it settled.
   // In slow mode every other cycle is a stall, to exercise the hold path.
   always @(negedge sys_clk) begin
      phase <= ~phase;
      rx_ready <= !stall && (!slow || phase);
   end

   always @(posedge sys_clk) begin
      if (!sys_rst && rx_valid && rx_ready) begin
         got.push_back(rx_word);
      end
   end
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the receive status bus packer.
// Assumes the default eight-word buffer, so nine words fit before a stall.
`timescale 1ns/100ps
module tb_top;
   import rfsbp_pkg::*;
   typedef struct packed {
      logic [4:0]  m;
      logic [19:0] lo;
      logic [19:0] hi;
      logic [31:0] w;
   } rfsbp_tbrow_type;
   logic           sys_clk, sys_rst, in_valid, in_ready, rx_valid, rx_ready, stall, slow;
   logic [31:0]    rx_word;
   rfsbp_mode_type mode;
   rfsbp_lane_type lane_lo, lane_hi;
   int             failures, check_count, base, n;
   // Mode is {width, enc_8b10b, pipe}; lanes are raw 20-bit records.
   // The last row's width code is not one-hot and must fall back to the 8-bit layout.
   rfsbp_tbrow_type rows [7] = '{
      '{5'h06, 20'ha96af, 20'hfffff, 32'h0000d5a5},
      '{5'h05, 20'ha96af, 20'hfffff, 32'h0000f4a5},
      '{5'h0a, 20'ha96af, 20'hfffff, 32'h0000d6a5},
      '{5'h09, 20'h00042, 20'hfffff, 32'h00002800},
      '{5'h12, 20'ha96af, 20'h4f150, 32'h2a3cd5a5},
      '{5'h11, 20'ha96af, 20'h4f150, 32'h083cf4a5},
      '{5'h1e, 20'ha96af, 20'hfffff, 32'h0000d5a5}};

   rfsbp_top #(.FIFO_DEPTH(8)) u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .mode(mode),
      .lane_lo(lane_lo), .lane_hi(lane_hi), .in_valid(in_valid), .in_ready(in_ready),
      .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready));
   rfsbp_sink u_sink (.sys_clk(sys_clk), .sys_rst(sys_rst), .rx_word(rx_word),
      .rx_valid(rx_valid), .stall(stall), .slow(slow), .rx_ready(rx_ready));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic wait_got(input int cnt);
      for (int i = 0; i < 60 && u_sink.got.size() < cnt; i++) begin
         @(negedge sys_clk);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Under two hundred cycles are expected; the limit leaves ample margin.
   initial begin
      #25000;
      failures++;
      results();
   end

   initial begin
      sys_rst = 1'b1;
      in_valid = 1'b0;
      stall = 1'b0;
      slow = 1'b0;
      mode = 5'h06;
      lane_lo = 20'h00000;
      lane_hi = 20'h00000;
      failures = 0;
      check_count = 0;
      repeat (6) @(negedge sys_clk);
      check("reset valid", {31'h0, rx_valid}, 32'h0);
      check("reset ready", {31'h0, in_ready}, 32'h1);
      check("reset word", rx_word, 32'h0);
      $display("reset values done");
      sys_rst = 1'b0;
      @(negedge sys_clk);
      // Back-to-back takes with the layout changing on every word.
      foreach (rows[i]) begin
         mode = rows[i].m;
         lane_lo = rows[i].lo;
         lane_hi = rows[i].hi;
         in_valid = 1'b1;
         @(negedge sys_clk);
      end
      in_valid = 1'b0;
      wait_got(7);
      foreach (rows[i]) begin
         check("table word", u_sink.got[i], rows[i].w);
      end
      $display("layout table done");
      // Fill against a stalled consumer until the buffer refuses.
      base = u_sink.got.size();
      stall = 1'b1;
      mode = 5'h08;
      n = 0;
      while (in_ready === 1'b1 && n < 20) begin
         lane_lo = 20'(n << 10);
         in_valid = 1'b1;
         @(negedge sys_clk);
         n++;
      end
      check("words taken", 32'(n), 32'd9);
      lane_lo = 20'hffc00;
      repeat (3) @(negedge sys_clk);
      check("refused ready", {31'h0, in_ready}, 32'h0);
      in_valid = 1'b0;
      slow = 1'b1;
      stall = 1'b0;
      wait_got(base + 9);
      repeat (6) @(negedge sys_clk);
      check("drained count", 32'(u_sink.got.size()), 32'(base + 9));
      for (int i = 0; i < 9; i++) begin
         check("drained word", u_sink.got[base + i], 32'(i));
      end
      $display("fill and drain done");
      // Reset in mid-run drops queued words.
      stall = 1'b1;
      in_valid = 1'b1;
      repeat (2) @(negedge sys_clk);
      in_valid = 1'b0;
      sys_rst = 1'b1;
      base = u_sink.got.size();
      @(negedge sys_clk);
      check("rerst valid", {31'h0, rx_valid}, 32'h0);
      check("rerst ready", {31'h0, in_ready}, 32'h1);
      check("rerst word", rx_word, 32'h0);
      sys_rst = 1'b0;
      stall = 1'b0;
      repeat (6) @(negedge sys_clk);
      check("rerst count", 32'(u_sink.got.size()), 32'(base));
      $display("mid-run reset done");
      results();
   end
endmodule
